// ===== ocu_monitor.sv
`timescale 1ns/100ps
module ocu_monitor
  import ocu_pkg::*;
#(
  parameter int CHANNEL_INDEX = 0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic [15:0] time_base_a_i,
  input wire logic [15:0] time_base_b_i,
  input wire logic fault_input_a_i,
  input wire logic port_level_i,
  input wire logic compare_output_pin_o,
  input wire logic pin_owned_o,
  input wire logic dma_req_o,
  input wire logic irq_o
);
  logic [2:0] mode_r;
  logic pnz_r;
  logic [3:0] fh_r;
  logic [15:0] ta_r;
  logic [15:0] tb_r;
  wire wr = psel_i && penable_i && pwrite_i;
  wire wc = wr && paddr_i == OCU_CTRL_OFS;
  wire chg = ta_r != time_base_a_i || tb_r != time_base_b_i;
  wire pin = compare_output_pin_o;
  // shadow of mode and primary, fault history
  always_ff @(posedge clk_i) begin
    ta_r <= time_base_a_i;
    tb_r <= time_base_b_i;
    fh_r <= reset_i ? 4'hf : {fh_r[2:0], fault_input_a_i};
    if (reset_i) begin
      mode_r <= 3'h0;
      pnz_r <= 1'b0;
    end else begin
      if (wc) mode_r <= pwdata_i[2:0];
      if (wr && paddr_i == OCU_PRI_OFS) pnz_r <= pwdata_i[15:0] != 16'h0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  AST_OFF_PIN:
    assert property (!pin_owned_o |-> pin == port_level_i) else $error("pin");
  AST_DMA:
    assert property (CHANNEL_INDEX >= 2 |-> !dma_req_o) else $error("dma");
  AST_PAD:
    assert property (psel_i && penable_i && !pwrite_i && !paddr_i |->
      prdata_o[31:14] == 18'h0 && prdata_o[12:5] == 8'h0) else $error("pad");
  AST_EVT:
    assert property (pin_owned_o && $past(pin_owned_o) && $changed(pin) |->
      $past(chg) || $past(wc) || fh_r != 4'hf) else $error("evt");
  AST_LOW_INIT:
    assert property (mode_r inside {OCU_SET_HIGH, OCU_ONE_PULSE, OCU_PULSES}
      && $past(wc) |-> !pin) else $error("init");
  AST_SET_LO:
    assert property (mode_r == OCU_SET_LOW |-> ($past(wc) ? pin : !$rose(pin)))
      else $error("low");
  AST_PWM_INIT:
    assert property (mode_r inside {OCU_PWM, OCU_PWM_FAULT} && $past(wc) |->
      pin == pnz_r) else $error("pwm");
  AST_FLT_PIN:
    assert property (mode_r == OCU_PWM_FAULT && fh_r == 4'h0 |-> !pin)
      else $error("flt");
  cover property (irq_o);
  cover property (dma_req_o);
  cover property ($rose(pin));
endmodule
bind ocu_top ocu_monitor #(.CHANNEL_INDEX(CHANNEL_INDEX)) u_mon (.*);

// ===== ocu_pin_load.sv
`timescale 1ns/100ps
module ocu_pin_load (
  input wire logic clk_i,
  input wire logic pin_i,
  output logic [7:0] rises_o
);
  logic last_r = 1'b1;
  initial rises_o = 8'h0;
  // counts rising edges seen by the load
  always @(posedge clk_i) begin
    last_r <= pin_i;
    if (pin_i && !last_r) rises_o <= rises_o + 8'h1;
  end
endmodule

// ===== ocu_pkg.sv
package ocu_pkg;
  localparam logic [7:0] OCU_CTRL_OFS = 8'h00;
  localparam logic [7:0] OCU_PRI_OFS = 8'h04;
  localparam logic [7:0] OCU_SEC_OFS = 8'h08;
  localparam logic [7:0] OCU_STAT_OFS = 8'h0c;
  localparam logic [7:0] OCU_MASK_OFS = 8'h10;

  localparam int OCU_MODE_LSB = 0;
  localparam int OCU_TSEL_BIT = 3;
  localparam int OCU_FLT_BIT = 4;
  localparam int OCU_IDLE_BIT = 13;

  localparam int OCU_IRQ_CMP_BIT = 0;
  localparam int OCU_IRQ_FLT_BIT = 1;
  localparam int OCU_IRQ_W = 2;

  localparam logic [15:0] OCU_CTRL_RST = 16'h0000;
  localparam logic [15:0] OCU_CMP_RST = 16'h0000;
  localparam logic [1:0] OCU_IRQ_RST = 2'h0;
  localparam logic [1:0] OCU_DMA_CHANNELS = 2'h2;

  typedef enum logic [2:0] {
    OCU_OFF = 3'b000,
    OCU_SET_HIGH = 3'b001,
    OCU_SET_LOW = 3'b010,
    OCU_TOGGLE = 3'b011,
    OCU_ONE_PULSE = 3'b100,
    OCU_PULSES = 3'b101,
    OCU_PWM = 3'b110,
    OCU_PWM_FAULT = 3'b111
  } ocu_mode_t;

  typedef struct packed {
    logic idle_halt;
    logic fault;
    logic tsel;
    ocu_mode_t mode;
  } ocu_ctrl_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } ocu_edge_t;
endpackage

// ===== ocu_top.sv
`timescale 1ns/100ps
// What this block does
// - bit 3 picks time base b, else a
// - compare count against one or two values
// - pin changes on compare matches, pwm period start, fault and control writes
// - mode field bits 2:0; 000 disables channel
// - mode 001: start low, match drives high
// - mode 010: start high, match drives low
// - mode 011: keep level, toggle on match
// - mode 100: single pulse, irq on fall
// - mode 101: pulse train, irq each fall
// - mode 110: pwm, no fault, no irq
// - mode 111: pwm, irq on fault fall
// - fault flag set in 111, control write clears it unless the fault input is still low in 111 while the channel runs
// - idle halt bit stops channel in idle
// - only first two channels request dma
// - unimplemented control bits ignore writes, read zero
module ocu_top
  import ocu_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int CHANNEL_INDEX = 0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [CNT_W-1:0] time_base_a_i,
  input wire logic [CNT_W-1:0] time_base_b_i,
  input wire logic cpu_idle_i,
  input wire logic fault_input_a_i,
  input wire logic port_level_i,
  output logic compare_output_pin_o,
  output logic pin_owned_o,
  output logic dma_req_o,
  output logic irq_o
);

  ocu_ctrl_t ctrl_r;
  ocu_ctrl_t ctrl_nxt;
  logic [CNT_W-1:0] pri_r;
  logic [CNT_W-1:0] sec_r;
  logic [OCU_IRQ_W-1:0] stat_r;
  logic [OCU_IRQ_W-1:0] stat_nxt;
  logic [OCU_IRQ_W-1:0] mask_r;
  logic [31:0] prdata_r;
  logic [CNT_W-1:0] prev_cnt_r;
  logic out_r;
  logic out_nxt;
  logic done_r;
  logic done_nxt;
  logic fault_s1_r;
  logic fault_s2_r;
  logic fault_d_r;
  logic dma_r;

  // bus decode
  wire setup = psel_i && !penable_i;
  wire access = psel_i && penable_i;
  wire hit_ctrl = (paddr_i == OCU_CTRL_OFS);
  wire hit_pri = (paddr_i == OCU_PRI_OFS);
  wire hit_sec = (paddr_i == OCU_SEC_OFS);
  wire hit_stat = (paddr_i == OCU_STAT_OFS);
  wire hit_mask = (paddr_i == OCU_MASK_OFS);
  wire mapped = hit_ctrl || hit_pri || hit_sec || hit_stat || hit_mask;
  wire wr = access && pwrite_i && mapped;
  wire wr_ctrl = wr && hit_ctrl;
  wire rd_stat = access && !pwrite_i && hit_stat;

  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;
  assign prdata_o = prdata_r;

  // control register view, unimplemented bits zero
  wire [15:0] ctrl_view = {2'h0, ctrl_r.idle_halt, 8'h00, ctrl_r.fault,
                           ctrl_r.tsel, ctrl_r.mode};
  wire [31:0] rd_mux =
    hit_ctrl ? {16'h0000, ctrl_view} :
    hit_pri ? {{(32-CNT_W){1'b0}}, pri_r} :
    hit_sec ? {{(32-CNT_W){1'b0}}, sec_r} :
    hit_stat ? {{(32-OCU_IRQ_W){1'b0}}, stat_r} :
    hit_mask ? {{(32-OCU_IRQ_W){1'b0}}, mask_r} : 32'h0000_0000;

  // channel timing
  wire [CNT_W-1:0] cnt = ctrl_r.tsel ? time_base_b_i
                                     : time_base_a_i;
  wire run = !(cpu_idle_i && ctrl_r.idle_halt);
  wire moved = (cnt != prev_cnt_r);
  wire match_pri = run && moved && (cnt == pri_r);
  wire match_sec = run && moved && (cnt == sec_r);
  wire period_start = run && moved && (cnt == '0);
  wire fault_low = !fault_s2_r;
  wire fault_fall = fault_d_r && !fault_s2_r;
  wire pwm_init = (pri_r != '0);
  wire [2:0] new_mode = pwdata_i[OCU_MODE_LSB +: 3];
  wire is_pwm_fault = (ctrl_r.mode == OCU_PWM_FAULT);

  // mode written: load initial pin level
  function automatic logic init_level(input logic [2:0] m,
                                      input logic cur,
                                      input logic pwm_hi);
    case (m)
      OCU_SET_LOW: init_level = 1'b1;
      OCU_TOGGLE: init_level = cur;
      OCU_PWM: init_level = pwm_hi;
      OCU_PWM_FAULT: init_level = pwm_hi;
      default: init_level = 1'b0;
    endcase
  endfunction

  // output level engine
  always_comb begin
    out_nxt = out_r;
    done_nxt = done_r;
    case (ctrl_r.mode)
      OCU_SET_HIGH: begin
        if (match_pri) out_nxt = 1'b1;
      end
      OCU_SET_LOW: begin
        if (match_pri) out_nxt = 1'b0;
      end
      OCU_TOGGLE: begin
        if (match_pri) out_nxt = !out_r;
      end
      OCU_ONE_PULSE: begin
        if (!done_r && match_pri) out_nxt = 1'b1;
        if (!done_r && out_r && match_sec) begin
          out_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      OCU_PULSES: begin
        if (match_pri) out_nxt = 1'b1;
        if (out_r && match_sec) out_nxt = 1'b0;
      end
      OCU_PWM: begin
        if (period_start) out_nxt = pwm_init;
        if (match_pri) out_nxt = 1'b0;
      end
      OCU_PWM_FAULT: begin
        if (period_start) out_nxt = pwm_init;
        if (match_pri) out_nxt = 1'b0;
        if (ctrl_r.fault || fault_low) out_nxt = 1'b0;
      end
      default: begin
        out_nxt = 1'b0;
        done_nxt = 1'b0;
      end
    endcase
    if (wr_ctrl) begin
      out_nxt = init_level(new_mode, out_r, pwm_init);
      done_nxt = 1'b0;
    end
  end

  // edges on the running pin
  ocu_edge_t edge_w;
  assign edge_w.rise = !wr_ctrl && !out_r && out_nxt;
  assign edge_w.fall = !wr_ctrl && out_r && !out_nxt;

  logic cmp_evt;
  always_comb begin
    case (ctrl_r.mode)
      OCU_SET_HIGH: cmp_evt = edge_w.rise;
      OCU_SET_LOW: cmp_evt = edge_w.fall;
      OCU_TOGGLE: cmp_evt = edge_w.rise || edge_w.fall;
      OCU_ONE_PULSE: cmp_evt = edge_w.fall;
      OCU_PULSES: cmp_evt = edge_w.fall;
      OCU_PWM_FAULT: cmp_evt = run && fault_fall;
      default: cmp_evt = 1'b0;
    endcase
  end

  wire flt_set = is_pwm_fault && run && fault_low;

  // control register next value; a write clears the fault flag, set wins
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt.idle_halt = pwdata_i[OCU_IDLE_BIT];
      ctrl_nxt.tsel = pwdata_i[OCU_TSEL_BIT];
      ctrl_nxt.mode = ocu_mode_t'(new_mode);
      ctrl_nxt.fault = 1'b0;
    end
    if (flt_set) ctrl_nxt.fault = 1'b1;
  end

  // sticky status, set wins over read clear
  always_comb begin
    stat_nxt = stat_r;
    if (rd_stat) stat_nxt = stat_r & ~prdata_r[OCU_IRQ_W-1:0];
    if (cmp_evt) stat_nxt[OCU_IRQ_CMP_BIT] = 1'b1;
    if (flt_set && !ctrl_r.fault) stat_nxt[OCU_IRQ_FLT_BIT] = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_r <= ocu_ctrl_t'(OCU_CTRL_RST[5:0]);
      pri_r <= OCU_CMP_RST;
      sec_r <= OCU_CMP_RST;
      mask_r <= OCU_IRQ_RST;
      stat_r <= OCU_IRQ_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      stat_r <= stat_nxt;
      if (wr && hit_pri) pri_r <= pwdata_i[CNT_W-1:0];
      if (wr && hit_sec) sec_r <= pwdata_i[CNT_W-1:0];
      if (wr && hit_mask) mask_r <= pwdata_i[OCU_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_r <= 32'h0000_0000;
      prev_cnt_r <= '0;
      out_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      prdata_r <= setup ? rd_mux : prdata_r;
      prev_cnt_r <= cnt;
      out_r <= out_nxt;
      done_r <= done_nxt;
    end
  end

  // fault pin synchroniser and edge history
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fault_s1_r <= 1'b1;
      fault_s2_r <= 1'b1;
      fault_d_r <= 1'b1;
    end else begin
      fault_s1_r <= fault_input_a_i;
      fault_s2_r <= fault_s1_r;
      fault_d_r <= fault_s2_r;
    end
  end

  // dma request pulse, first channels only
  generate
    if (CHANNEL_INDEX < OCU_DMA_CHANNELS) begin : g_dma
      always_ff @(posedge clk_i) begin
        if (reset_i) dma_r <= 1'b0;
        else dma_r <= cmp_evt;
      end
    end else begin : g_nodma
      assign dma_r = 1'b0;
    end
  endgenerate

  assign dma_req_o = dma_r;
  assign pin_owned_o = (ctrl_r.mode != OCU_OFF);
  assign compare_output_pin_o = pin_owned_o ? out_r : port_level_i;
  assign irq_o = |(stat_r & mask_r);

endmodule

// ===== output_compare_unit_tb.sv
`timescale 1ns/100ps
module output_compare_unit_tb;
  import ocu_pkg::*;
  logic clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic [15:0] ta = 8, tb = 0;
  logic idle = 0, fault = 1, er, pin, own, dma, irq, pready, perr;
  logic plev = 1;
  logic [7:0] rises;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  ocu_top dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .time_base_a_i(ta), .time_base_b_i(tb),
    .cpu_idle_i(idle), .fault_input_a_i(fault), .port_level_i(plev),
    .compare_output_pin_o(pin), .pin_owned_o(own), .dma_req_o(dma),
    .irq_o(irq));
  ocu_pin_load u_load (.clk_i(clk_i), .pin_i(pin), .rises_o(rises));
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      test_done;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // timers stay still during register accesses
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task go(input logic [15:0] v);
    @(posedge clk_i);
    tb <= v;
    ta <= v + 16'h8;
    @(posedge clk_i);
    #1;
  endtask
  task t_regs;
    acc(0, OCU_CTRL_OFS, 0);
    chk(rd, 0);
    acc(1, OCU_CTRL_OFS, 32'hffff_ffff);
    acc(0, OCU_CTRL_OFS, 0);
    chk(rd, 32'h200f);
    acc(0, 8'h14, 0);
    chk(rd, 0);
    chk(er, 1);
    acc(1, OCU_CTRL_OFS, 0);
    chk({own, pin}, 2'b01);
    @(posedge clk_i);
    plev <= 0;
    @(posedge clk_i);
    #1;
    chk(pin, 0);
    @(posedge clk_i);
    plev <= 1;
    acc(1, OCU_PRI_OFS, 5);
    acc(1, OCU_SEC_OFS, 7);
    acc(1, OCU_MASK_OFS, 3);
  endtask
  task t_one(input logic [2:0] m, input logic i0);
    acc(1, OCU_CTRL_OFS, {28'h0, 1'b1, m});
    chk(pin, i0);
    go(4);
    go(5);
    chk(pin, !i0);
    chk(dma, 1);
    go(6);
    chk(irq, 1);
    chk(dma, 0);
    acc(0, OCU_STAT_OFS, 0);
    chk(rd, 1);
    go(6);
    chk(irq, 0);
  endtask
  task t_tog;
    go(4);
    go(5);
    chk(pin, 0);
    acc(0, OCU_STAT_OFS, 0);
    chk(rd, 1);
  endtask
  task t_shot;
    go(4);
    acc(1, OCU_CTRL_OFS, 32'hc);
    go(5);
    chk(pin, 1);
    acc(0, OCU_STAT_OFS, 0);
    chk(rd, 0);
    go(7);
    chk(pin, 0);
    go(5);
    chk(pin, 0);
    acc(0, OCU_STAT_OFS, 0);
    chk(rd, 1);
  endtask
  task t_train;
    logic [7:0] r0;
    r0 = rises;
    acc(1, OCU_CTRL_OFS, 32'hd);
    repeat (2) begin
      go(7);
      go(5);
    end
    go(7);
    chk(rises - r0, 2);
    acc(0, OCU_STAT_OFS, 0);
    chk(rd, 1);
  endtask
  task t_pwm;
    acc(1, OCU_CTRL_OFS, 32'he);
    chk(pin, 1);
    go(5);
    chk(pin, 0);
    go(0);
    chk(pin, 1);
    acc(0, OCU_STAT_OFS, 0);
    chk(rd, 0);
  endtask
  task t_fault;
    acc(1, OCU_CTRL_OFS, 32'hf);
    @(posedge clk_i);
    fault <= 0;
    repeat (4) @(posedge clk_i);
    #1;
    chk(pin, 0);
    acc(0, OCU_CTRL_OFS, 0);
    chk(rd, 32'h1f);
    acc(0, OCU_STAT_OFS, 0);
    chk(rd, 3);
    @(posedge clk_i);
    fault <= 1;
    go(5);
    go(0);
    chk(pin, 0);
    acc(1, OCU_CTRL_OFS, 0);
    acc(0, OCU_CTRL_OFS, 0);
    chk(rd, 0);
  endtask
  task t_idle;
    acc(1, OCU_CTRL_OFS, 32'h2009);
    @(posedge clk_i);
    idle <= 1;
    go(4);
    go(5);
    chk(pin, 0);
    @(posedge clk_i);
    idle <= 0;
    go(4);
    go(5);
    chk(pin, 1);
  endtask
  task t_tsel;
    acc(1, OCU_CTRL_OFS, 32'h1);
    go(16'h5);
    chk(pin, 0);
    go(16'hfffd);
    chk(pin, 1);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 0;
    t_regs;
    t_one(3'h1, 1'b0);
    t_one(3'h2, 1'b1);
    t_one(3'h3, 1'b0);
    t_tog;
    t_shot;
    t_train;
    t_pwm;
    t_fault;
    t_idle;
    t_tsel;
    test_done;
  end
endmodule
